/* hw/ppc_pkg.sv */
// Package for the privilege protection checker: register map, fields, encodings.
// Assumes an AHB-Lite master with single word transfers and one slave.
package ppc_pkg;
	// Register byte offsets
	localparam logic [7:0] PPC_CTRL_OFS   = 8'h00;
	localparam logic [7:0] PPC_BANKP_OFS  = 8'h04;
	localparam logic [7:0] PPC_STAT_OFS   = 8'h08;
	localparam logic [7:0] PPC_MASK_OFS   = 8'h0C;
	localparam logic [7:0] PPC_INFO_OFS   = 8'h10;
	localparam logic [7:0] PPC_COUNT_OFS  = 8'h14;
	// Control register fields
	localparam int PPC_CTRL_SUP_BIT   = 0;
	localparam int PPC_CTRL_HALTD_BIT = 1;
	// Status / mask fields
	localparam int PPC_EV_TRAP_BIT = 0;
	localparam int PPC_EV_MODE_BIT = 1;
	localparam int PPC_EV_W        = 2;
	// Reset values
	localparam logic        PPC_SUP_RST   = 1'b1;
	localparam logic [15:0] PPC_BANKP_RST = 16'h0000;
	localparam logic [PPC_EV_W-1:0] PPC_MASK_RST = 2'h0;
	// Vectors below this trap in user mode
	localparam logic [7:0]  PPC_VEC_LIMIT = 8'h40;
	localparam int          PPC_BANK_SHIFT = 4;
	// Operation class of the presented instruction
	typedef enum logic [3:0] {
		PPC_OP_ALU,
		PPC_OP_LOAD,
		PPC_OP_STORE,
		PPC_OP_MTSR,
		PPC_OP_MFSR,
		PPC_OP_MTTLB,
		PPC_OP_MFTLB,
		PPC_OP_IRET,
		PPC_OP_IRETINV,
		PPC_OP_INV,
		PPC_OP_HALT,
		PPC_OP_ASSERT,
		PPC_OP_EMULATE
	} ppc_op_t;
	// Trap cause codes
	typedef enum logic [3:0] {
		PPC_C_NONE,
		PPC_C_TLB,
		PPC_C_BANK,
		PPC_C_PAUA,
		PPC_C_AS,
		PPC_C_PRIV_INS,
		PPC_C_PRIV_SR,
		PPC_C_VECTOR,
		PPC_C_OPERAND
	} ppc_cause_t;
	typedef enum logic [1:0] {
		PPC_BUS_IDLE,
		PPC_BUS_DATA
	} ppc_bus_t;
	// Privileged special register numbers
	localparam logic [7:0] PPC_SR_VAB  = 8'h00;
	localparam logic [7:0] PPC_SR_LRU  = 8'h0E;
endpackage : ppc_pkg

/* hw/ppc_checker.sv */
// Privilege mode and protection violation checking with an AHB-Lite register slave.
// Assumes the pipeline presents one decoded instruction per valid cycle and
// the bus request valid marks the address cycle of each outward request.
// What this block does
// - Mode bit one means supervisor mode
// - Mode bit zero means user mode, exclusive
// - Supervisor request drives privilege output high
// - User request drives privilege output low
// - User TLB entry access traps
// - User access to protected bank traps
// - User load/store with physical or override traps
// - Translated alternate space access always traps
// - User return, invalidate, halt instructions trap
// - Debug may disable halt check for breakpoints
// - User privileged special register access traps
// - User assert/emulate vectors 0..63 trap
// - Special/TLB registers only via explicit moves
// - Supervisor ignores bank protection
// - Bank protection has 16 bits, bank order
// - Local registers offset by stack pointer first
`timescale 1ns/100ps
module ppc_checker
	import ppc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ins_valid,
	input  wire ppc_op_t     ins_op,
	input  wire logic [7:0]  ins_ra,
	input  wire logic [7:0]  ins_rb,
	input  wire logic [7:0]  ins_rc,
	input  wire logic [2:0]  ins_reg_used,
	input  wire logic [7:0]  ins_sr_num,
	input  wire logic        ins_sr_is_operand,
	input  wire logic [7:0]  ins_vector,
	input  wire logic        ins_translated,
	input  wire logic        physical_access_bit,
	input  wire logic        user_access_override_bit,
	input  wire logic        alternate_space_bit,
	input  wire logic [31:0] stack_pointer,
	input  wire logic        halt_check_disable,
	input  wire logic        mode_load,
	input  wire logic        mode_load_value,
	input  wire logic        bus_req_valid,
	output logic             privilege_level_output,
	output logic             supervisor_mode,
	output logic             prot_trap,
	output logic [3:0]       prot_cause,
	output logic             commit_enable,
	output logic             irq
);
	logic                supervisor_mode_bit_r;
	logic                sup_nxt;
	logic [15:0]         bankp_r;
	logic                haltd_r;
	logic [PPC_EV_W-1:0] stat_r;
	logic [PPC_EV_W-1:0] mask_r;
	logic [3:0]          cause_r;
	logic [15:0]         count_r;
	logic                priv_out_r;
	logic                wr_pend_r;
	logic [7:0]          wr_addr_r;
	logic [31:0]         rdata_nxt;
	ppc_bus_t            bus_r;
	ppc_bus_t            bus_nxt;
	ppc_cause_t          cause_nxt;

	// Absolute register number; local registers add SP bits 8..2
	function automatic logic [7:0] abs_reg(input logic [7:0] rn, input logic [31:0] sp);
		logic [6:0] sum;
		sum = rn[6:0] + sp[8:2];
		abs_reg = rn[7] ? {1'b1, sum} : rn;
	endfunction : abs_reg

	function automatic logic bank_hit(input logic [7:0] ar, input logic [15:0] bp);
		bank_hit = bp[ar[7:PPC_BANK_SHIFT]];
	endfunction : bank_hit

	wire user_mode = ~supervisor_mode_bit_r;
	wire [7:0] abs_a = abs_reg(ins_ra, stack_pointer);
	wire [7:0] abs_b = abs_reg(ins_rb, stack_pointer);
	wire [7:0] abs_c = abs_reg(ins_rc, stack_pointer);
	// Bank map covers all 16 banks in order
	wire bank_a = ins_reg_used[0] && bank_hit(abs_a, bankp_r);
	wire bank_b = ins_reg_used[1] && bank_hit(abs_b, bankp_r);
	wire bank_c = ins_reg_used[2] && bank_hit(abs_c, bankp_r);
	wire bank_v = bank_a || bank_b || bank_c;

	// Operation class decode
	wire is_load    = (ins_op == PPC_OP_LOAD);
	wire is_store   = (ins_op == PPC_OP_STORE);
	wire is_mttlb   = (ins_op == PPC_OP_MTTLB);
	wire is_mftlb   = (ins_op == PPC_OP_MFTLB);
	wire is_mtsr    = (ins_op == PPC_OP_MTSR);
	wire is_mfsr    = (ins_op == PPC_OP_MFSR);
	wire is_iret    = (ins_op == PPC_OP_IRET);
	wire is_iretinv = (ins_op == PPC_OP_IRETINV);
	wire is_inv     = (ins_op == PPC_OP_INV);
	wire is_halt    = (ins_op == PPC_OP_HALT);
	wire is_assert  = (ins_op == PPC_OP_ASSERT);
	wire is_emulate = (ins_op == PPC_OP_EMULATE);

	wire is_ldst  = is_load || is_store;
	wire is_tlb   = is_mttlb || is_mftlb;
	wire is_sr    = is_mtsr || is_mfsr;
	wire priv_sr  = is_sr && (ins_sr_num >= PPC_SR_VAB) && (ins_sr_num <= PPC_SR_LRU);

	// Pin or control bit lifts the halt check so halt can act as a breakpoint
	wire halt_off = haltd_r || halt_check_disable;
	wire halt_chk = is_halt && !halt_off;
	wire priv_ins = is_iret || is_iretinv || is_inv || halt_chk;
	wire vec_ins  = is_assert || is_emulate;

	// Only the alternate space and operand terms ignore the mode
	wire v_as      = is_ldst && ins_translated && alternate_space_bit;
	wire v_operand = ins_sr_is_operand && !is_sr && !is_tlb;
	wire v_tlb     = user_mode && is_tlb;
	wire v_bank    = user_mode && bank_v;
	wire v_paua    = user_mode && is_ldst
		&& (physical_access_bit || user_access_override_bit);
	wire v_pins    = user_mode && priv_ins;
	wire v_sr      = user_mode && priv_sr;
	wire v_vec     = user_mode && vec_ins && (ins_vector < PPC_VEC_LIMIT);
	wire any_v     = ins_valid && (v_operand | v_tlb | v_bank | v_paua | v_pins | v_sr
		| v_vec | v_as);

	// Priority order picks one reported cause
	always_comb begin
		cause_nxt = PPC_C_NONE;
		if (!ins_valid)
			cause_nxt = PPC_C_NONE;
		else if (v_operand)
			cause_nxt = PPC_C_OPERAND;
		else if (v_tlb)
			cause_nxt = PPC_C_TLB;
		else if (v_sr)
			cause_nxt = PPC_C_PRIV_SR;
		else if (v_pins)
			cause_nxt = PPC_C_PRIV_INS;
		else if (v_vec)
			cause_nxt = PPC_C_VECTOR;
		else if (v_paua)
			cause_nxt = PPC_C_PAUA;
		else if (v_as)
			cause_nxt = PPC_C_AS;
		else if (v_bank)
			cause_nxt = PPC_C_BANK;
	end

	// Trap is combinational so the same cycle's writeback can be blocked
	assign prot_trap     = any_v;
	assign prot_cause    = cause_nxt;
	assign commit_enable = ins_valid && !any_v;
	assign supervisor_mode = supervisor_mode_bit_r;

	// Bus decode
	wire addr_ph  = hsel && hready && htrans[1];
	wire wr_start = addr_ph && hwrite;
	wire rd_start = addr_ph && !hwrite;
	wire wr_take  = wr_pend_r && (bus_r == PPC_BUS_DATA);
	wire ctrl_wr  = wr_take && (wr_addr_r == PPC_CTRL_OFS);
	wire bankp_wr = wr_take && (wr_addr_r == PPC_BANKP_OFS);
	wire stat_wr  = wr_take && (wr_addr_r == PPC_STAT_OFS);
	wire mask_wr  = wr_take && (wr_addr_r == PPC_MASK_OFS);
	wire [PPC_EV_W-1:0] ev = {mode_load && (mode_load_value != supervisor_mode_bit_r),
		any_v};
	wire [PPC_EV_W-1:0] clr = stat_wr ? hwdata[PPC_EV_W-1:0] : '0;

	// Pipeline load wins over a same-cycle control write
	always_comb begin
		sup_nxt = supervisor_mode_bit_r;
		if (ctrl_wr)
			sup_nxt = hwdata[PPC_CTRL_SUP_BIT];
		if (mode_load)
			sup_nxt = mode_load_value;
	end

	wire [31:0] ctrl_word  = {30'h0, haltd_r, supervisor_mode_bit_r};
	wire [31:0] bankp_word = {16'h0, bankp_r};
	wire [31:0] stat_word  = {30'h0, stat_r};
	wire [31:0] mask_word  = {30'h0, mask_r};
	wire [31:0] info_word  = {28'h0, cause_r};
	wire [31:0] count_word = {16'h0, count_r};

	always_comb begin
		case (haddr[7:0])
			PPC_CTRL_OFS:  rdata_nxt = ctrl_word;
			PPC_BANKP_OFS: rdata_nxt = bankp_word;
			PPC_STAT_OFS:  rdata_nxt = stat_word;
			PPC_MASK_OFS:  rdata_nxt = mask_word;
			PPC_INFO_OFS:  rdata_nxt = info_word;
			PPC_COUNT_OFS: rdata_nxt = count_word;
			default:       rdata_nxt = 32'h0;
		endcase
	end

	// Control and mapping registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			supervisor_mode_bit_r <= PPC_SUP_RST;
		else
			supervisor_mode_bit_r <= sup_nxt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			haltd_r <= 1'b0;
		else if (ctrl_wr)
			haltd_r <= hwdata[PPC_CTRL_HALTD_BIT];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			bankp_r <= PPC_BANKP_RST;
		else if (bankp_wr)
			bankp_r <= hwdata[15:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mask_r <= PPC_MASK_RST;
		else if (mask_wr)
			mask_r <= hwdata[PPC_EV_W-1:0];
	end

	// Set wins over write-one-to-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			stat_r <= '0;
		else
			stat_r <= (stat_r & ~clr) | ev;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cause_r <= 4'h0;
		else if (any_v)
			cause_r <= cause_nxt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			count_r <= 16'h0000;
		else if (any_v)
			count_r <= count_r + 16'h0001;
	end

	// Holds the level shown in the last address cycle between requests
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			priv_out_r <= PPC_SUP_RST;
		else if (bus_req_valid)
			priv_out_r <= supervisor_mode_bit_r;
	end
	assign privilege_level_output = bus_req_valid ? supervisor_mode_bit_r : priv_out_r;

	// Bus slave state
	always_comb begin
		case (bus_r)
			PPC_BUS_IDLE: bus_nxt = addr_ph ? PPC_BUS_DATA : PPC_BUS_IDLE;
			PPC_BUS_DATA: bus_nxt = addr_ph ? PPC_BUS_DATA : PPC_BUS_IDLE;
			default:      bus_nxt = PPC_BUS_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			bus_r <= PPC_BUS_IDLE;
		else
			bus_r <= bus_nxt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_pend_r <= 1'b0;
		else
			wr_pend_r <= wr_start;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_addr_r <= 8'h00;
		else if (addr_ph)
			wr_addr_r <= haddr[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (rd_start)
			hrdata <= rdata_nxt;
	end

	// Zero wait states, always OKAY
	wire [PPC_EV_W-1:0] pend = stat_r & mask_r;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign irq       = |pend;
endmodule : ppc_checker

/* verif/ppc_checker_asserts.sv */
// Port-level checks of privilege level and trap decisions.
// Bound to ppc_checker; watches only its ports.
`timescale 1ns/100ps
module ppc_checker_asserts
	import ppc_pkg::*;
(
	input wire logic    hclk,
	input wire logic    hresetn,
	input wire logic    ins_valid,
	input wire ppc_op_t ins_op,
	input wire logic    ins_translated,
	input wire logic    physical_access_bit,
	input wire logic    user_access_override_bit,
	input wire logic    alternate_space_bit,
	input wire logic    halt_check_disable,
	input wire logic    mode_load,
	input wire logic    mode_load_value,
	input wire logic    bus_req_valid,
	input wire logic    privilege_level_output,
	input wire logic    supervisor_mode,
	input wire logic    prot_trap,
	input wire logic    commit_enable
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire u = ins_valid && !supervisor_mode;
	wire ls = ins_op inside {PPC_OP_LOAD, PPC_OP_STORE};
	chk_priv_high: assert property (bus_req_valid && supervisor_mode |-> privilege_level_output)
		else $error("privilege output low in supervisor");
	chk_priv_low: assert property (bus_req_valid && !supervisor_mode |-> !privilege_level_output)
		else $error("privilege output high in user");
	chk_tlb_user: assert property (u && ins_op inside {PPC_OP_MTTLB, PPC_OP_MFTLB} |-> prot_trap)
		else $error("user tlb access not trapped");
	chk_paua_user: assert property (u && ls && (physical_access_bit || user_access_override_bit) |-> prot_trap)
		else $error("user physical access not trapped");
	chk_alt_space: assert property (ins_valid && ls && ins_translated && alternate_space_bit |-> prot_trap)
		else $error("alternate space not trapped");
	chk_priv_ins: assert property (u && (ins_op inside {PPC_OP_IRET, PPC_OP_IRETINV, PPC_OP_INV}
		|| ins_op == PPC_OP_HALT && !halt_check_disable) |-> prot_trap)
		else $error("user privileged instruction not trapped");
	chk_commit_gate: assert property (ins_valid |-> commit_enable == !prot_trap)
		else $error("commit not gated by trap");
	chk_mode_load: assert property (mode_load |=> supervisor_mode == $past(mode_load_value))
		else $error("mode bit not loaded");
	cov_user_trap: cover property (u && prot_trap);
	cov_sup_trap: cover property (ins_valid && supervisor_mode && prot_trap);
	cov_user_req: cover property (bus_req_valid && !supervisor_mode);
endmodule : ppc_checker_asserts

bind ppc_checker ppc_checker_asserts u_asserts (.hclk, .hresetn, .ins_valid, .ins_op,
	.ins_translated, .physical_access_bit, .user_access_override_bit, .alternate_space_bit,
	.halt_check_disable, .mode_load, .mode_load_value, .bus_req_valid,
	.privilege_level_output, .supervisor_mode, .prot_trap, .commit_enable);

/* verif/ppc_bus_device.sv */
// Bus device model that latches the privilege level of each request.
// Assumes bus_req_valid marks the address cycle.
`timescale 1ns/100ps
module ppc_bus_device (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic bus_req_valid,
	input wire logic privilege_level_output,
	output logic     seen_sup
);
	// Resets low so a supervisor sample is never free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			seen_sup <= 1'b0;
		else if (bus_req_valid)
			seen_sup <= privilege_level_output;
	end
endmodule : ppc_bus_device

/* verif/privilege_protection_checker_bench.sv */
// Bench for the protection checker: AHB register access and trap checks.
// Assumes one slave whose hreadyout drives hready.
`timescale 1ns/100ps
module privilege_protection_checker_bench;
	import ppc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ins_valid = 1'b0;
	logic ins_sr_is_operand = 1'b0, ins_translated = 1'b0, physical_access_bit = 1'b0;
	logic user_access_override_bit = 1'b0, alternate_space_bit = 1'b0, halt_check_disable = 1'b0;
	logic mode_load = 1'b0, mode_load_value = 1'b0, bus_req_valid = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, stack_pointer = 32'h0, hrdata, q;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2, ins_reg_used = 3'h7;
	logic [7:0]  ins_sr_num = 8'h80, ins_vector = 8'hFF;
	logic [3:0]  prot_cause;
	logic        hreadyout, hresp, privilege_level_output, supervisor_mode, prot_trap;
	logic        commit_enable, irq, seen_sup;
	ppc_op_t     ins_op = PPC_OP_ALU;
	ppc_op_t     pl[4] = '{PPC_OP_IRET, PPC_OP_IRETINV, PPC_OP_INV, PPC_OP_HALT};
	int          n_errors = 0, comparisons = 0, n_traps = 0;
	always #10 hclk = ~hclk;
	ppc_checker uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .ins_valid, .ins_op, .ins_ra(ins_sr_num),
		.ins_rb(ins_sr_num), .ins_rc(ins_sr_num), .ins_reg_used, .ins_sr_num, .ins_sr_is_operand,
		.ins_vector, .ins_translated, .physical_access_bit, .user_access_override_bit,
		.alternate_space_bit, .stack_pointer, .halt_check_disable, .mode_load, .mode_load_value,
		.bus_req_valid, .privilege_level_output, .supervisor_mode, .prot_trap, .prot_cause,
		.commit_enable, .irq);
	ppc_bus_device dev (.hclk, .hresetn, .bus_req_valid, .privilege_level_output, .seen_sup);
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
		cmp("hresp", 32'h0, 32'(hresp));
		#1;
	endtask : ahb
	// Register number shares the special register field to save ports
	task ins(input ppc_op_t op, input logic [7:0] r, input ppc_cause_t c);
		@(posedge hclk);
		ins_valid <= 1'b1;
		ins_op <= op;
		ins_sr_num <= r;
		#5;
		cmp("trap", 32'({c, c != PPC_C_NONE, c == PPC_C_NONE}),
			32'({prot_cause, prot_trap, commit_enable}));
		if (c != PPC_C_NONE) n_traps++;
		@(posedge hclk);
		ins_valid <= 1'b0;
	endtask : ins
	task pulse(input logic m, input logic v);
		@(posedge hclk);
		if (m) mode_load <= 1'b1;
		else bus_req_valid <= 1'b1;
		mode_load_value <= v;
		@(posedge hclk);
		mode_load <= 1'b0;
		bus_req_valid <= 1'b0;
		#1;
		cmp("mode", 32'(v), 32'(m ? supervisor_mode : seen_sup));
	endtask : pulse
	task stop_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, PPC_CTRL_OFS, 32'h0); cmp("ctrl", 32'h1, q);
		ahb(1'b0, 8'h40, 32'h0); cmp("unmapped", 32'h0, q);
		pulse(1'b0, 1'b1);
		ahb(1'b1, PPC_BANKP_OFS, 32'h0220);
		ahb(1'b0, PPC_BANKP_OFS, 32'h0); cmp("bankp", 32'h0220, q);
		ins(PPC_OP_ALU, 8'h50, PPC_C_NONE);
		ahb(1'b1, PPC_CTRL_OFS, 32'h0); cmp("sup", 32'h0, 32'(supervisor_mode));
		pulse(1'b0, 1'b0);
		ins(PPC_OP_ALU, 8'h50, PPC_C_BANK);
		ins(PPC_OP_ALU, 8'h81, PPC_C_NONE);
		stack_pointer <= 32'h40;
		ins(PPC_OP_ALU, 8'h81, PPC_C_BANK);
		ahb(1'b1, PPC_MASK_OFS, 32'h1); cmp("irq", 32'h1, 32'(irq));
		ahb(1'b1, PPC_STAT_OFS, 32'h3); cmp("irq", 32'h0, 32'(irq));
		ahb(1'b1, PPC_INFO_OFS, 32'h0); ahb(1'b0, PPC_INFO_OFS, 32'h0);
		cmp("info", 32'(PPC_C_BANK), q);
		ahb(1'b0, PPC_COUNT_OFS, 32'h0); cmp("count", 32'(n_traps), q);
		foreach (pl[i]) ins(pl[i], 8'h40, PPC_C_PRIV_INS);
		halt_check_disable <= 1'b1;
		ins(PPC_OP_HALT, 8'h40, PPC_C_NONE);
		ins(PPC_OP_MTTLB, 8'h40, PPC_C_TLB);
		ins(PPC_OP_MFTLB, 8'h40, PPC_C_TLB);
		ins(PPC_OP_MTSR, 8'h00, PPC_C_PRIV_SR);
		ins(PPC_OP_MFSR, 8'h0E, PPC_C_PRIV_SR);
		ins_vector <= 8'h3F;
		ins(PPC_OP_ASSERT, 8'h40, PPC_C_VECTOR);
		ins(PPC_OP_EMULATE, 8'h40, PPC_C_VECTOR);
		ins_vector <= 8'h40;
		ins(PPC_OP_EMULATE, 8'h40, PPC_C_NONE);
		physical_access_bit <= 1'b1;
		ins(PPC_OP_LOAD, 8'h40, PPC_C_PAUA);
		physical_access_bit <= 1'b0;
		user_access_override_bit <= 1'b1;
		ins(PPC_OP_STORE, 8'h40, PPC_C_PAUA);
		user_access_override_bit <= 1'b0;
		ins_translated <= 1'b1;
		alternate_space_bit <= 1'b1;
		pulse(1'b1, 1'b1);
		ahb(1'b0, PPC_STAT_OFS, 32'h0); cmp("stat", 32'h3, q);
		ins(PPC_OP_LOAD, 8'h40, PPC_C_AS);
		ins(PPC_OP_MTTLB, 8'h40, PPC_C_NONE);
		ins_sr_is_operand <= 1'b1;
		ins(PPC_OP_ALU, 8'h40, PPC_C_OPERAND);
		stop_test();
	end
endmodule : privilege_protection_checker_bench
